// >>> hw/count_if.sv
/*
  Carrier between the register block and one 8-bit period counter.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/10ps
interface count_if;
  logic tick;
  logic run;
  logic [7:0] period;
  logic [7:0] count;
  logic wrap;
  modport ctrl (output tick, output run, output period,
                input count, input wrap);
  modport cnt (input tick, input run, input period,
               output count, output wrap);
endinterface

// >>> hw/period_counter.sv
/*
  One 8-bit up counter that wraps to zero after matching its period.
  Assumes tick is a one-cycle enable from the core clock domain.
*/
`timescale 1ns/10ps
module period_counter import timer_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  count_if.cnt cif
);
  typedef struct packed {
    logic [7:0] count;
    logic wrap;
  } cnt_state_t;

  cnt_state_t st;
  cnt_state_t next_st;

  ////////////////////////////////////////////////////////////////////
  // count, match and wrap
  always_comb begin
    next_st = st;
    next_st.wrap = 1'b0;
    // R13 stopped counter
    if (cif.tick && cif.run) begin
      // R10 wrap after match
      if (st.count == cif.period) begin
        next_st.count = 8'h00;
        next_st.wrap = 1'b1;
      end else begin
        next_st.count = st.count + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cif.count = st.count;
  assign cif.wrap = st.wrap;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_wrap_to_zero: assert property ( // R10
    cif.tick && cif.run && st.count == cif.period
    |=> st.count == 8'h00 && st.wrap)
    else $error("counter did not wrap after period match");
  a_count_step: assert property ( // R10
    cif.tick && cif.run && st.count != cif.period
    |=> st.count == $past(st.count) + 8'h01 && !st.wrap)
    else $error("counter did not step by one");
  a_stopped_quiet: assert property ( // R13
    !cif.run |=> $stable(st.count) && !st.wrap)
    else $error("stopped counter moved or wrapped");
endmodule

// >>> hw/timer_ctrl.sv
/*
  Dual 8-bit period timers with capture overrun status and third
  pulse output pin control, behind an Avalon-MM slave with waitrequest.
  Assumes pins arrive asynchronously, capture_time_base and pulse_wave
  come from logic on core_clk, and the core clock is the oscillator.
*/
// The Avalon-MM register port was decided locally.
// Overview of operation
// R1 - A capture arriving before the prior value is read sets overrun.
// R2 - After overrun the oldest value stays until both bytes are read.
// R3 - Edge mode picks falling, rising, 4th rising or 16th rising edge.
// R4 - Channel four mode sits in bits 4-3, channel three in bits 2-1.
// R5 - With the pulse enable set the pin is driven regardless of dir.
// R6 - Bit 7 of the capture/pulse control register always reads zero.
// R7 - With the join bit clear the timers run as two 8-bit counters.
// R8 - Each timer chooses its clock source on its own.
// R9 - Select clear counts instruction cycles, set counts pin falls.
// R10 - A timer counts from zero to its period then returns to zero.
// R11 - Each timer latches its own flag when it wraps to zero.
// R12 - The interrupt needs enable, peripheral enable and no disable.
// R13 - A timer counts only while its run bit is set.
// R14 - The external clock is synchronised before it is counted.
// R15 - Synchroniser then falling-edge detect gives a count enable.
`timescale 1ns/10ps
module timer_ctrl import timer_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic shared_timer_clock_pin,
  input wire logic capture_three_pin,
  input wire logic capture_four_pin,
  input wire logic [15:0] capture_time_base,
  input wire logic pulse_wave,
  input wire logic third_pulse_out_pin_in,
  output logic third_pulse_out_pin_out,
  output logic third_pulse_out_pin_oe,
  output logic timer_irq
);
  // channel index 0 is capture three, 1 is capture four
  typedef struct packed {
    bus_state_t bus;
    logic waitrequest;
    logic [31:0] readdata;
    logic [4:0] timer_ctrl;
    logic [1:0][7:0] period;
    logic [1:0] wrap_flag;
    logic [3:0] irq_ctrl;
    logic [4:0] cp_ctrl;
    logic [1:0] port_g;
    logic [1:0] cyc_div;
    logic cyc_tick;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] level;
    logic ext_fall;
    logic [1:0][3:0] presc;
    logic [1:0][15:0] cap_val;
    logic [1:0] cap_full;
    logic [1:0] cap_ovr;
    logic [1:0] rd_lo;
    logic [1:0] rd_hi;
    logic irq;
    logic pin_out;
    logic pin_oe;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;

  logic [3:0] agree;
  logic [3:0] fall;
  logic [3:0] rise;
  logic [5:0] idx;
  logic take;
  logic wr_lo;
  logic [7:0] rbyte;
  logic [1:0] mode;
  logic [1:0] cap_hit;
  logic [1:0] compl;
  logic [1:0] ovr_cause;
  logic irq_cond;
  logic [1:0][7:0] cnt;
  logic [1:0] wrap;
  logic [1:0] tick;

  ////////////////////////////////////////////////////////////////////
  // two period counters, one per timer
  count_if cif[2] ();

  for (genvar i = 0; i < 2; i++) begin : g_tmr
    // R7 separate counters
    // R8 per-timer source
    // R9 cycle or pin clock
    assign tick[i] = ~st.timer_ctrl[TC_JOIN] &
      (st.timer_ctrl[TC_CS_LSB + i] ? st.ext_fall : st.cyc_tick);
    assign cif[i].tick = tick[i];
    // R13 run gates counting
    assign cif[i].run = st.timer_ctrl[TC_RUN_LSB + i];
    assign cif[i].period = st.period[i];
    assign cnt[i] = cif[i].count;
    assign wrap[i] = cif[i].wrap;
    period_counter u_cnt (
      .core_clk(core_clk),
      .nrst(nrst),
      .cif(cif[i])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // read data selection from current state
  always_comb begin
    rbyte = 8'h00;
    case (idx)
      IDX_TIMER_CTRL: rbyte = {3'h0, st.timer_ctrl};
      IDX_PERIOD0: rbyte = st.period[0];
      IDX_PERIOD1: rbyte = st.period[1];
      IDX_COUNT0: rbyte = cnt[0];
      IDX_COUNT1: rbyte = cnt[1];
      IDX_WRAP_FLAGS: rbyte = {6'h00, st.wrap_flag};
      IDX_IRQ_CTRL: rbyte = {4'h0, st.irq_ctrl};
      IDX_CAP3_LO: rbyte = st.cap_val[0][7:0];
      IDX_CAP3_HI: rbyte = st.cap_val[0][15:8];
      IDX_CAP4_LO: rbyte = st.cap_val[1][7:0];
      IDX_CAP4_HI: rbyte = st.cap_val[1][15:8];
      IDX_PORT_G: rbyte = {5'h00, st.level[3], st.port_g};
      // R6 top bit reads zero
      IDX_CAP_PWM3: rbyte = {1'b0, st.cap_ovr[1], st.cap_ovr[0],
                             st.cp_ctrl};
      default: rbyte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_st = st;
    idx = address[IDX_LSB +: 6];
    // a request takes effect only at the edge waitrequest is low
    take = (st.bus == BUS_ANSWER) && (read || write);
    wr_lo = take && write && byteenable[0];
    agree = 4'h0;
    fall = 4'h0;
    rise = 4'h0;
    mode = 2'h0;
    cap_hit = 2'h0;
    compl = 2'h0;
    ovr_cause = 2'h0;
    irq_cond = 1'b0;

    // bus handshake: one wait cycle, then one answer cycle
    case (st.bus)
      BUS_IDLE: begin
        if (read || write) begin
          next_st.bus = BUS_ANSWER;
          next_st.waitrequest = 1'b0;
          next_st.readdata = read ? {24'h000000, rbyte} : 32'h0;
        end
      end
      BUS_ANSWER: begin
        next_st.bus = BUS_IDLE;
        next_st.waitrequest = 1'b1;
      end
      default: begin
        next_st.bus = BUS_IDLE;
        next_st.waitrequest = 1'b1;
      end
    endcase

    // register writes; unmapped indices are ignored
    if (wr_lo) begin
      case (idx)
        IDX_TIMER_CTRL: next_st.timer_ctrl = writedata[4:0];
        IDX_PERIOD0: next_st.period[0] = writedata[7:0];
        IDX_PERIOD1: next_st.period[1] = writedata[7:0];
        IDX_IRQ_CTRL: next_st.irq_ctrl = writedata[3:0];
        IDX_PORT_G: next_st.port_g = writedata[1:0];
        IDX_CAP_PWM3: begin
          // R4 both mode fields writable
          next_st.cp_ctrl = writedata[4:0];
          // restart prescalers so a new mode starts clean
          next_st.presc = '0;
        end
        default: next_st.port_g = st.port_g;
      endcase
    end

    // R11 flags set on wrap, write one clears, set wins
    next_st.wrap_flag = st.wrap_flag & ~((wr_lo &&
      idx == IDX_WRAP_FLAGS) ? writedata[1:0] : 2'h0);
    next_st.wrap_flag = next_st.wrap_flag | wrap;

    // capture byte reads, tracked only while a value is unread
    if (take && read) begin
      if (idx == IDX_CAP3_LO) next_st.rd_lo[0] = st.cap_full[0];
      if (idx == IDX_CAP3_HI) next_st.rd_hi[0] = st.cap_full[0];
      if (idx == IDX_CAP4_LO) next_st.rd_lo[1] = st.cap_full[1];
      if (idx == IDX_CAP4_HI) next_st.rd_hi[1] = st.cap_full[1];
    end

    // instruction-cycle enable, core clock divided by four
    next_st.cyc_div = st.cyc_div + 2'h1;
    next_st.cyc_tick = (st.cyc_div == CYC_LAST);

    // R14 three-stage pin synchroniser
    next_st.sync1 = {third_pulse_out_pin_in, capture_four_pin,
                     capture_three_pin, shared_timer_clock_pin};
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    // a level change counts once stages two and three agree
    agree = ~(st.sync2 ^ st.sync3);
    next_st.level = (st.level & ~agree) | (st.sync3 & agree);
    fall = st.level & ~st.sync3 & agree;
    rise = ~st.level & st.sync3 & agree;
    // R15 falling edge gives one-cycle count enable
    next_st.ext_fall = fall[0];

    for (int c = 0; c < 2; c++) begin
      mode = st.cp_ctrl[CP_MODE3_LSB + 2 * c +: 2];
      // R3 edge selection
      case (mode)
        EDGE_FALL: cap_hit[c] = fall[c + 1];
        EDGE_RISE: cap_hit[c] = rise[c + 1];
        EDGE_RISE4: begin
          if (rise[c + 1]) begin
            cap_hit[c] = (st.presc[c] >= PRESC_4);
            next_st.presc[c] = cap_hit[c] ? 4'h0 :
                               st.presc[c] + 4'h1;
          end
        end
        EDGE_RISE16: begin
          if (rise[c + 1]) begin
            cap_hit[c] = (st.presc[c] == PRESC_16);
            next_st.presc[c] = st.presc[c] + 4'h1;
          end
        end
        default: cap_hit[c] = 1'b0;
      endcase

      // R2 both bytes read releases the pair
      compl[c] = next_st.rd_lo[c] && next_st.rd_hi[c];
      if (compl[c]) begin
        next_st.cap_full[c] = 1'b0;
        next_st.cap_ovr[c] = 1'b0;
        next_st.rd_lo[c] = 1'b0;
        next_st.rd_hi[c] = 1'b0;
      end

      ovr_cause[c] = cap_hit[c] && st.cap_full[c] && !compl[c];
      if (ovr_cause[c]) begin
        // R1 unread value overrun
        // R2 oldest value kept
        next_st.cap_ovr[c] = 1'b1;
      end else if (cap_hit[c]) begin
        next_st.cap_val[c] = capture_time_base;
        next_st.cap_full[c] = 1'b1;
      end
    end

    // R12 three-way interrupt gate
    irq_cond = |(st.wrap_flag & st.irq_ctrl[IC_IE_LSB +: 2]) &&
               st.irq_ctrl[IC_PERIPHERAL_IRQ_ENABLE] && !st.irq_ctrl[IC_GLOBAL_IRQ_DISABLE];
    next_st.irq = irq_cond;

    // R5 pulse enable overrides direction
    next_st.pin_oe = st.cp_ctrl[CP_PWM3] || !st.port_g[PG_DIR];
    next_st.pin_out = st.cp_ctrl[CP_PWM3] ? pulse_wave :
                      st.port_g[PG_DATA];
  end

  ////////////////////////////////////////////////////////////////////
  // state register; pin defaults to input, global disable set
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.bus <= BUS_IDLE;
      st.waitrequest <= 1'b1;
      st.timer_ctrl <= TC_RESET;
      st.irq_ctrl <= IC_RESET;
      st.cp_ctrl <= CP_RESET;
      st.port_g <= PG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // every output straight from the state register
  assign readdata = st.readdata;
  assign waitrequest = st.waitrequest;
  assign timer_irq = st.irq;
  assign third_pulse_out_pin_out = st.pin_out;
  assign third_pulse_out_pin_oe = st.pin_oe;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic wr_cp;
  assign wr_cp = wr_lo && idx == IDX_CAP_PWM3;

  sequence ext_drop;
    st.level[0] && !st.sync2[0] && !st.sync3[0];
  endsequence

  sequence one_fall_pulse;
    st.ext_fall ##1 !st.ext_fall;
  endsequence

  a_overrun_set: assert property ( // R1
    (st.cap_ovr & $past(ovr_cause)) == $past(ovr_cause))
    else $error("overrun bit not set on unread capture");
  a_hold_oldest: assert property ( // R2
    ovr_cause[0] |=> st.cap_val[0] == $past(st.cap_val[0]))
    else $error("capture value replaced during overrun");
  a_div4_mode: assert property ( // R3
    cap_hit[0] && st.cp_ctrl[2:1] == EDGE_RISE4
    |-> st.presc[0] == PRESC_4 && rise[1])
    else $error("fourth-edge capture at wrong edge");
  a_mode_write: assert property ( // R4
    wr_cp |=> st.cp_ctrl == $past(writedata[4:0]))
    else $error("edge mode fields not written");
  a_pin_forced: assert property ( // R5
    st.cp_ctrl[CP_PWM3] |=> st.pin_oe)
    else $error("pin not driven with pulse enable set");
  a_reserved_zero: assert property ( // R6
    !st.waitrequest && read && idx == IDX_CAP_PWM3
    |-> st.readdata[31:7] == 25'h0)
    else $error("unimplemented bit read as one");
  a_cycle_rate: assert property ( // R9
    st.cyc_tick |=> !st.cyc_tick [*3] ##1 st.cyc_tick)
    else $error("instruction tick not one in four");
  a_flag_latch: assert property ( // R11
    (st.wrap_flag & $past(wrap)) == $past(wrap))
    else $error("wrap flag not latched");
  a_irq_gate: assert property ( // R12
    st.irq == $past(irq_cond))
    else $error("interrupt not gated by enables");
  a_ext_sync: assert property ( // R15
    ext_drop |=> one_fall_pulse)
    else $error("pin fall did not give one enable");
endmodule

// >>> hw/timer_pkg.sv
/*
  Shared constants for the dual 8-bit timer and capture control block:
  register indices, field positions, reset values and timing counts.
  Assumes a 32-bit Avalon-MM slave with byte addresses, one word per
  register, byte address equal to four times the register index.
*/
package timer_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int IDX_LSB = 2;

  // register indices
  localparam logic [5:0] IDX_TIMER_CTRL = 6'h00;
  localparam logic [5:0] IDX_PERIOD0 = 6'h01;
  localparam logic [5:0] IDX_PERIOD1 = 6'h02;
  localparam logic [5:0] IDX_COUNT0 = 6'h03;
  localparam logic [5:0] IDX_COUNT1 = 6'h04;
  localparam logic [5:0] IDX_WRAP_FLAGS = 6'h05;
  localparam logic [5:0] IDX_IRQ_CTRL = 6'h06;
  localparam logic [5:0] IDX_CAP3_LO = 6'h07;
  localparam logic [5:0] IDX_CAP3_HI = 6'h08;
  localparam logic [5:0] IDX_CAP4_LO = 6'h09;
  localparam logic [5:0] IDX_CAP4_HI = 6'h0a;
  localparam logic [5:0] IDX_PORT_G = 6'h0b;
  localparam logic [5:0] IDX_CAP_PWM3 = 6'h16;

  // timer control fields
  localparam int TC_CS_LSB = 0;
  localparam int TC_RUN_LSB = 2;
  localparam int TC_JOIN = 4;
  localparam logic [4:0] TC_RESET = 5'h00;

  // interrupt control fields
  localparam int IC_IE_LSB = 0;
  localparam int IC_PERIPHERAL_IRQ_ENABLE = 2;
  localparam int IC_GLOBAL_IRQ_DISABLE = 3;
  localparam logic [3:0] IC_RESET = 4'h8;

  // capture / third pulse control fields
  localparam int CP_PWM3 = 0;
  localparam int CP_MODE3_LSB = 1;
  localparam int CP_OVR3 = 5;
  localparam int CP_OVR4 = 6;
  localparam logic [4:0] CP_RESET = 5'h00;

  // port g fields
  localparam int PG_DIR = 0;
  localparam int PG_DATA = 1;
  localparam int PG_PIN = 2;
  localparam logic [1:0] PG_RESET = 2'h1;

  // instruction cycle is core clock divided by four
  localparam int OSC_PER_CYC = 4;
  localparam logic [1:0] CYC_LAST = 2'(OSC_PER_CYC - 1);

  // rising-edge prescale terminal counts
  localparam logic [3:0] PRESC_4 = 4'h3;
  localparam logic [3:0] PRESC_16 = 4'hf;

  typedef enum logic [1:0] {
    EDGE_FALL, EDGE_RISE, EDGE_RISE4, EDGE_RISE16
  } edge_mode_t;

  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage

// >>> sim/ext_clock_src.sv
/*
  Far-side model: an external source making falling edges on the
  shared timer clock pin, promptly or slowly on request.
  Assumes the caller runs on the same core clock as the block.
*/
`timescale 1ns/10ps
module ext_clock_src (
  input wire logic core_clk,
  output logic shared_timer_clock_pin
);
  // pin stands high between bursts so each fall is a fresh edge
  initial shared_timer_clock_pin = 1'b1;

  //////////////////////////////////////////////////////////////////////
  // pin falls, levels held long enough for the synchroniser
  task automatic make_falls(input int n, input bit slow);
    int hold;
    hold = slow ? 7 : 3;
    repeat (n) begin
      @(posedge core_clk);
      shared_timer_clock_pin <= 1'b0;
      repeat (hold) @(posedge core_clk);
      shared_timer_clock_pin <= 1'b1;
      repeat (hold) @(posedge core_clk);
    end
  endtask
endmodule

// >>> sim/test_timer_ctrl.sv
/*
  Self-checking bench for timer_ctrl: register access over Avalon-MM,
  external clock counting, interrupt gating, capture modes, pin control.
  Assumes the package constants and a one-wait-state bus answer.
*/
`timescale 1ns/10ps
module test_timer_ctrl import timer_pkg::*;;
  logic core_clk, nrst, read, write, waitrequest, pulse_wave;
  logic pin_out, pin_oe, timer_irq;
  logic [ADDR_W-1:0] address;
  logic [31:0] writedata, readdata;
  logic [1:0] cap_pin;
  logic [15:0] capture_time_base;
  wire ext_pin;
  // pin level seen back: our drive when enabled, else far side high
  wire pin_wire = pin_oe ? pin_out : 1'b1;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int edges_per[4] = '{1, 1, 4, 16};

  timer_ctrl u_timer_ctrl (.core_clk(core_clk), .nrst(nrst),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
    .waitrequest(waitrequest), .shared_timer_clock_pin(ext_pin),
    .capture_three_pin(cap_pin[0]), .capture_four_pin(cap_pin[1]),
    .capture_time_base(capture_time_base), .pulse_wave(pulse_wave),
    .third_pulse_out_pin_in(pin_wire), .third_pulse_out_pin_out(pin_out),
    .third_pulse_out_pin_oe(pin_oe), .timer_irq(timer_irq));
  ext_clock_src u_ext_clock_src (.core_clk(core_clk),
    .shared_timer_clock_pin(ext_pin));

  //////////////////////////////////////////////////////////////////////
  // clock and hang guard; a long run means a lost answer somewhere
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  // one bus transfer held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, wd};
    // wait as long as it takes; only the hang guard ends a lost answer
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    // one wait cycle, answer sampled at the second edge
    check("bus answer edges", 16'(n), 16'h2);
  endtask

  task automatic wr_reg(input logic [5:0] idx, input logic [7:0] wd);
    logic [7:0] dummy;
    bus(1'b1, idx, wd, dummy);
  endtask

  task automatic chk_reg(input string what, input logic [5:0] idx,
                         input logic [7:0] exp);
    logic [7:0] v;
    bus(1'b0, idx, 8'h00, v);
    check(what, 16'(v), 16'(exp));
  endtask

  task automatic falls(input int n, input bit slow);
    u_ext_clock_src.make_falls(n, slow);
    repeat (6) @(posedge core_clk);
  endtask

  // pulses on one capture pin; time base differs at rise and at fall
  task automatic cap_edges(input int ch, input int n, input int base);
    for (int k = 1; k <= n; k++) begin
      @(posedge core_clk);
      capture_time_base <= 16'(base + k);
      cap_pin[ch] <= 1'b1;
      repeat (8) @(posedge core_clk);
      capture_time_base <= 16'h8000 | 16'(base + k);
      cap_pin[ch] <= 1'b0;
      repeat (8) @(posedge core_clk);
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic [7:0] mb;
    logic [15:0] e;
    int nn;
    nrst = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    cap_pin = 2'b00;
    capture_time_base = 16'h0000;
    pulse_wave = 1'b0;
    repeat (2) @(posedge core_clk);
    check("wait in reset", 16'(waitrequest), 16'h1);
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    // register defaults, writable fields, unmapped place
    chk_reg("irq ctrl reset", IDX_IRQ_CTRL, 8'h08);
    chk_reg("cap ctrl reset", IDX_CAP_PWM3, 8'h00);
    wr_reg(IDX_CAP_PWM3, 8'hfe);
    chk_reg("cap ctrl rw", IDX_CAP_PWM3, 8'h1e);
    wr_reg(IDX_CAP_PWM3, 8'h00);
    chk_reg("unmapped", 6'h20, 8'h00);
    $display("test registers done");

    // external clock counting on both timers
    wr_reg(IDX_PERIOD0, 8'h02);
    wr_reg(IDX_PERIOD1, 8'hff);
    wr_reg(IDX_TIMER_CTRL, 8'h0f);
    falls(2, 1'b0);
    chk_reg("count0 ext", IDX_COUNT0, 8'h02);
    chk_reg("count1 ext", IDX_COUNT1, 8'h02);
    chk_reg("flags none", IDX_WRAP_FLAGS, 8'h00);
    falls(1, 1'b1);
    chk_reg("count0 wrap", IDX_COUNT0, 8'h00);
    chk_reg("count1 on", IDX_COUNT1, 8'h03);
    chk_reg("flag0 set", IDX_WRAP_FLAGS, 8'h01);
    wr_reg(IDX_TIMER_CTRL, 8'h1f);
    falls(2, 1'b0);
    chk_reg("count1 joined", IDX_COUNT1, 8'h03);
    wr_reg(IDX_TIMER_CTRL, 8'h0d);
    repeat (40) @(posedge core_clk);
    chk_reg("count0 no falls", IDX_COUNT0, 8'h00);
    bus(1'b0, IDX_COUNT1, 8'h00, v);
    check("count1 internal", 16'(v != 8'h03), 16'h1);
    $display("test external clock done");

    // internal clock wraps and interrupt gating
    wr_reg(IDX_WRAP_FLAGS, 8'h03);
    wr_reg(IDX_TIMER_CTRL, 8'h04);
    repeat (40) @(posedge core_clk);
    chk_reg("flag0 only", IDX_WRAP_FLAGS, 8'h01);
    wr_reg(IDX_IRQ_CTRL, 8'h0d);
    repeat (3) @(posedge core_clk);
    check("irq disabled", 16'(timer_irq), 16'h0);
    wr_reg(IDX_IRQ_CTRL, 8'h05);
    repeat (3) @(posedge core_clk);
    check("irq on", 16'(timer_irq), 16'h1);
    wr_reg(IDX_IRQ_CTRL, 8'h01);
    repeat (3) @(posedge core_clk);
    check("irq no periph", 16'(timer_irq), 16'h0);
    wr_reg(IDX_IRQ_CTRL, 8'h06);
    repeat (3) @(posedge core_clk);
    check("irq other timer", 16'(timer_irq), 16'h0);
    wr_reg(IDX_TIMER_CTRL, 8'h00);
    wr_reg(IDX_WRAP_FLAGS, 8'h03);
    bus(1'b0, IDX_COUNT0, 8'h00, v);
    repeat (40) @(posedge core_clk);
    chk_reg("count0 stopped", IDX_COUNT0, v);
    chk_reg("flags stopped", IDX_WRAP_FLAGS, 8'h00);
    $display("test internal clock done");

    // pin direction and pulse enable
    wr_reg(IDX_PORT_G, 8'h01);
    repeat (3) @(posedge core_clk);
    check("pin released", 16'(pin_oe), 16'h0);
    wr_reg(IDX_CAP_PWM3, 8'h01);
    pulse_wave <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("pulse oe", 16'(pin_oe), 16'h1);
    check("pulse high", 16'(pin_out), 16'h1);
    pulse_wave <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("pulse low", 16'(pin_out), 16'h0);
    wr_reg(IDX_CAP_PWM3, 8'h00);
    wr_reg(IDX_PORT_G, 8'h02);
    repeat (3) @(posedge core_clk);
    check("port oe", 16'(pin_oe), 16'h1);
    check("port data", 16'(pin_out), 16'h1);
    chk_reg("port readback", IDX_PORT_G, 8'h06);
    $display("test pin done");

    // every edge mode on both channels, then overrun holds oldest
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 4; m++) begin
        nn = edges_per[m];
        mb = ch ? 8'(m << 3) : 8'(m << 1);
        e = 16'(256 * (m + 1) + nn) | (m == 0 ? 16'h8000 : 16'h0000);
        wr_reg(IDX_CAP_PWM3, mb);
        cap_edges(ch, 2 * nn, 256 * (m + 1));
        chk_reg("overrun set", IDX_CAP_PWM3,
                mb | (ch ? 8'h40 : 8'h20));
        chk_reg("cap lo", ch ? IDX_CAP4_LO : IDX_CAP3_LO, e[7:0]);
        chk_reg("cap hi", ch ? IDX_CAP4_HI : IDX_CAP3_HI, e[15:8]);
        chk_reg("overrun clear", IDX_CAP_PWM3, mb);
      end
    end
    $display("test capture done");
    report_and_stop();
  end
endmodule
